// >>> stop_mode_power_sequencer.sv
// stop-mode power sequencer: entry, mode decode, exits, stop2 pin latch
// assumes synchronous single-cycle inputs from the cpu core and supervisors
//
// Contract
// - stop with allow bit enters stop
// - stop without allow forces illegal-opcode reset
// - stop halts clocks except low-frequency oscillator
// - mode chosen by mode-select control bits
// - stop1 powers off regulator-fed circuits, standby
// - stop1 exit restarts via reset vector
// - stop1 asserts low-voltage; waits supply re-arm
// - stop2 keeps ram, latches pins on entry
// - stop2 exit resets, pin latches stay closed
// - stop2 wake sets partial-powerdown flag
// - acknowledge write clears flag, opens latches
// - stop3 standby regulator, keeps state, no latch
// - stop3 reset takes reset, interrupts vectors
// - stop4 like stop3 with full regulation
// - medium oscillator on for sampling, detect, reading
// - parameter regs, low oscillator, wakeup always on; power_ctl holds all three off during reset
// - converter in stop4 only with its clock
// - rf buffer may run during stop
// - low-volt or debug turns stop1/2 into stop4
`timescale 1ns/1ps
module stop_mode_power_sequencer (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	// cpu
	input  wire logic                      stop_exec,
	input  wire logic                      stop_allow_bit,
	input  wire logic [1:0]                power_mode_control_two,
	input  wire logic                      partial_powerdown_acknowledge,
	input  wire logic                      lowvolt_in_stop_enable,
	input  wire logic                      debug_entry_enable,
	// wake sources
	input  wire logic                      wake_reset,
	input  wire logic                      wake_irq,
	input  wire logic                      wake_rti,
	input  wire logic                      supply_above_rearm,
	input  wire stop_seq_pkg::wake_src_t   wake_src,
	input  wire logic                      converter_clk_sel,
	input  wire logic                      rf_buffer_keep,
	// status and control out
	output logic                           illegal_op_reset,
	output logic                           in_stop,
	output logic [1:0]                     active_mode,
	output logic                           low_voltage_detect,
	output logic                           pin_latch_hold,
	output logic                           partial_powerdown_flag,
	output logic                           por_restart,
	output stop_seq_pkg::vec_sel_t         wake_vector,
	output stop_seq_pkg::power_ctl_t       power_ctl
);
	import stop_seq_pkg::*;

	seq_state_t state_ff, nxt_state;
	logic [1:0] mode_ff, nxt_mode;
	logic       ill_ff, nxt_ill;
	logic       uvd_ff, nxt_uvd;
	logic       latch_ff, nxt_latch;
	logic       flag_ff, nxt_flag;
	logic       por_ff, nxt_por;
	vec_sel_t   vec_ff, nxt_vec;
	power_ctl_t pwr_ff, nxt_pwr;
	logic       wake_any;
	logic [1:0] req_mode;

	assign wake_any = wake_reset | wake_irq | wake_rti;

	// mode request with low-volt/debug override
	always_comb begin
		req_mode = power_mode_control_two;
		if ((lowvolt_in_stop_enable | debug_entry_enable) &&
			(power_mode_control_two == MODE_STOP1 || power_mode_control_two == MODE_STOP2)) begin
			req_mode = MODE_STOP4;
		end
	end

	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_mode  = mode_ff;
		nxt_ill   = 1'b0;
		nxt_uvd   = uvd_ff;
		nxt_latch = latch_ff;
		nxt_flag  = flag_ff;
		nxt_por   = 1'b0;
		nxt_vec   = VEC_NONE;
		case (state_ff)
			ST_RUN: begin
				if (stop_exec && stop_allow_bit) begin
					nxt_state = ST_STOP;
					nxt_mode  = req_mode;
					if (req_mode == MODE_STOP1) begin
						nxt_uvd = 1'b1;
					end
					if (req_mode == MODE_STOP2) begin
						nxt_latch = 1'b1;
					end
				end else if (stop_exec) begin
					nxt_ill = 1'b1;
				end
			end
			ST_STOP: begin
				if (mode_ff == MODE_STOP1) begin
					if (wake_any && supply_above_rearm) begin
						nxt_state = ST_WAKE;
						nxt_uvd   = 1'b0;
						nxt_por   = 1'b1;
						nxt_vec   = VEC_RESET;
						nxt_latch = 1'b0;
					end
				end else if (wake_any) begin
					nxt_state = ST_WAKE;
					if (mode_ff == MODE_STOP2) begin
						nxt_por  = 1'b1;
						nxt_vec  = VEC_RESET;
						nxt_flag = 1'b1;
					end else if (wake_reset) begin
						nxt_por = 1'b1;
						nxt_vec = VEC_RESET;
					end else if (wake_irq) begin
						nxt_vec = VEC_IRQ;
					end else begin
						nxt_vec = VEC_RTI;
					end
				end
			end
			ST_WAKE: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
		// ack ignored in stop2, so a wake setting the flag wins
		if (partial_powerdown_acknowledge && !(state_ff == ST_STOP && mode_ff == MODE_STOP2)) begin
			nxt_flag = 1'b0;
			if (nxt_state != ST_STOP) begin
				nxt_latch = 1'b0;
			end
		end
	end

	// power domain enables
	always_comb begin
		nxt_pwr = '0;
		nxt_pwr.low_freq_oscillator_en  = 1'b1;
		nxt_pwr.periodic_wakeup_unit_en = 1'b1;
		nxt_pwr.param_regs_en           = 1'b1;
		nxt_pwr.rf_buffer_en            = rf_buffer_keep;
		if (nxt_state == ST_STOP) begin
			nxt_pwr.core_clk_en             = 1'b0;
			nxt_pwr.high_freq_oscillator_en = 1'b0;
			nxt_pwr.medium_freq_oscillator_en = wake_src.lowfreq_receiver_sampling | wake_src.lowfreq_receiver_detect
				| wake_src.sensor_reading;
			case (nxt_mode)
				MODE_STOP1: begin
					nxt_pwr.regulator_standby = 1'b1;
				end
				MODE_STOP2: begin
					nxt_pwr.regulator_standby = 1'b1;
					nxt_pwr.ram_en            = 1'b1;
				end
				MODE_STOP3: begin
					nxt_pwr.regulator_standby = 1'b1;
					nxt_pwr.ram_en            = 1'b1;
					nxt_pwr.reg_fed_en        = 1'b1;
				end
				default: begin
					nxt_pwr.regulator_full      = 1'b1;
					nxt_pwr.ram_en              = 1'b1;
					nxt_pwr.reg_fed_en          = 1'b1;
					nxt_pwr.analog_converter_en = converter_clk_sel;
				end
			endcase
		end else begin
			nxt_pwr.core_clk_en               = 1'b1;
			nxt_pwr.high_freq_oscillator_en   = 1'b1;
			nxt_pwr.medium_freq_oscillator_en = 1'b1;
			nxt_pwr.reg_fed_en                = 1'b1;
			nxt_pwr.ram_en                    = 1'b1;
			nxt_pwr.regulator_full            = 1'b1;
			nxt_pwr.analog_converter_en       = 1'b1;
			nxt_pwr.rf_buffer_en              = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_ff <= ST_RUN;
			mode_ff  <= MODE_STOP1;
			ill_ff   <= 1'b0;
			uvd_ff   <= 1'b0;
			latch_ff <= LATCH_RST;
			flag_ff  <= FLAG_RST;
			por_ff   <= 1'b0;
			vec_ff   <= VEC_NONE;
			pwr_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			mode_ff  <= nxt_mode;
			ill_ff   <= nxt_ill;
			uvd_ff   <= nxt_uvd;
			latch_ff <= nxt_latch;
			flag_ff  <= nxt_flag;
			por_ff   <= nxt_por;
			vec_ff   <= nxt_vec;
			pwr_ff   <= nxt_pwr;
		end
	end

	// outputs from flops
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			in_stop     <= 1'b0;
			active_mode <= MODE_STOP1;
		end else begin
			in_stop     <= (nxt_state == ST_STOP);
			active_mode <= nxt_mode;
		end
	end
	assign illegal_op_reset       = ill_ff;
	assign low_voltage_detect     = uvd_ff;
	assign pin_latch_hold         = latch_ff;
	assign partial_powerdown_flag = flag_ff;
	assign por_restart            = por_ff;
	assign wake_vector            = vec_ff;
	assign power_ctl              = pwr_ff;

	// checks
	a_no_stop_illegal: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_RUN && stop_exec && !stop_allow_bit |=> ill_ff && state_ff == ST_RUN)
		else $error("disallowed stop not refused");
	a_stop_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_RUN && stop_exec && stop_allow_bit |=> state_ff == ST_STOP)
		else $error("stop not entered");
	a_clocks_halted: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_STOP |-> !pwr_ff.core_clk_en && pwr_ff.low_freq_oscillator_en)
		else $error("clocks running in stop");
	a_override_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_RUN && stop_exec && stop_allow_bit && (debug_entry_enable || lowvolt_in_stop_enable)
		&& (power_mode_control_two == MODE_STOP1 || power_mode_control_two == MODE_STOP2)
		|=> mode_ff == MODE_STOP4)
		else $error("debug override missed");
	a_stop1_undervolt: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_STOP && mode_ff == MODE_STOP1 && !supply_above_rearm |=> state_ff == ST_STOP && uvd_ff)
		else $error("stop1 left below re-arm");
	a_stop2_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_STOP && mode_ff == MODE_STOP2 |-> latch_ff && pwr_ff.ram_en)
		else $error("stop2 latch open");
	a_stop2_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_STOP && mode_ff == MODE_STOP2 && wake_any |=> flag_ff && por_ff && latch_ff)
		else $error("stop2 wake flag missing");
	a_ack_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_RUN && partial_powerdown_acknowledge && !stop_exec |=> !flag_ff && !latch_ff)
		else $error("acknowledge did not release");
	a_stop3_irq_vec: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_STOP && mode_ff == MODE_STOP3 && wake_irq && !wake_reset |=> vec_ff == VEC_IRQ && !por_ff)
		else $error("stop3 irq vector wrong");
	a_stop4_full_reg: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_ff == ST_STOP && mode_ff == MODE_STOP4 |-> pwr_ff.regulator_full && !pwr_ff.regulator_standby)
		else $error("stop4 regulation lost");

endmodule

// >>> stop_seq_pkg.sv
// package for the stop-mode power sequencer
// assumes a single 250 MHz system clock domain
package stop_seq_pkg;

	// stop mode select encoding
	localparam logic [1:0] MODE_STOP1 = 2'h0;
	localparam logic [1:0] MODE_STOP2 = 2'h1;
	localparam logic [1:0] MODE_STOP3 = 2'h2;
	localparam logic [1:0] MODE_STOP4 = 2'h3;

	// reset values
	localparam logic       FLAG_RST  = 1'h0;
	localparam logic       LATCH_RST = 1'h0;

	// sequencer states, gray along run -> stop -> wake
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_STOP = 2'b01,
		ST_WAKE = 2'b11
	} seq_state_t;

	// wake vector selection
	typedef enum logic [1:0] {
		VEC_NONE  = 2'b00,
		VEC_RESET = 2'b01,
		VEC_IRQ   = 2'b10,
		VEC_RTI   = 2'b11
	} vec_sel_t;

	// power domain enables driven out
	typedef struct packed {
		logic core_clk_en;
		logic high_freq_oscillator_en;
		logic medium_freq_oscillator_en;
		logic low_freq_oscillator_en;
		logic periodic_wakeup_unit_en;
		logic param_regs_en;
		logic reg_fed_en;
		logic ram_en;
		logic regulator_full;
		logic regulator_standby;
		logic analog_converter_en;
		logic rf_buffer_en;
	} power_ctl_t;

	// activity requests during stop
	typedef struct packed {
		logic lowfreq_receiver_sampling;
		logic lowfreq_receiver_detect;
		logic sensor_reading;
	} wake_src_t;

endpackage

// >>> testbench.sv
// self-checking bench for the stop-mode power sequencer
// assumes the sequencer's own assertions run alongside
`timescale 1ns/1ps
module testbench;
	import stop_seq_pkg::*;
	logic              clk_sys;
	logic              rstn;
	logic              stop_exec;
	logic              stop_allow_bit;
	logic [1:0]        power_mode_control_two;
	logic              partial_powerdown_acknowledge;
	logic              lowvolt_in_stop_enable;
	logic              debug_entry_enable;
	logic              wake_reset;
	logic              wake_irq;
	logic              wake_rti;
	logic              supply_above_rearm;
	wake_src_t         wake_src;
	logic              converter_clk_sel;
	logic              rf_buffer_keep;
	logic              illegal_op_reset;
	logic              in_stop;
	logic [1:0]        active_mode;
	logic              low_voltage_detect;
	logic              pin_latch_hold;
	logic              partial_powerdown_flag;
	logic              por_restart;
	vec_sel_t          wake_vector;
	power_ctl_t        power_ctl;
	int                failures;
	int                n_compared;

	stop_mode_power_sequencer dut (.*);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// enter stop with mode select m
	task automatic go(input logic [1:0] m);
		@(posedge clk_sys);
		stop_exec <= 1'b1;
		power_mode_control_two <= m;
		@(posedge clk_sys);
		stop_exec <= 1'b0;
		#1;
	endtask

	// wake source pulse: 0 reset, 1 irq, 2 rti
	task automatic wk(input int k);
		@(posedge clk_sys);
		wake_reset <= (k == 0);
		wake_irq <= (k == 1);
		wake_rti <= (k == 2);
		@(posedge clk_sys);
		{wake_reset, wake_irq, wake_rti} <= 3'h0;
		#1;
	endtask

	task automatic ack();
		@(posedge clk_sys);
		partial_powerdown_acknowledge <= 1'b1;
		@(posedge clk_sys);
		partial_powerdown_acknowledge <= 1'b0;
		#1;
	endtask

	initial begin
		#20000;
		failures++;
		end_of_test();
	end

	initial begin
		failures = 0;
		n_compared = 0;
		rstn = 1'b0;
		{stop_exec, stop_allow_bit, partial_powerdown_acknowledge} = 3'h0;
		{lowvolt_in_stop_enable, debug_entry_enable, converter_clk_sel} = 3'h0;
		{wake_reset, wake_irq, wake_rti} = 3'h0;
		power_mode_control_two = 2'h0;
		supply_above_rearm = 1'b1;
		wake_src = '0;
		rf_buffer_keep = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk(power_ctl, 12'h000);
		chk(in_stop, 1'h0);
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(power_ctl.core_clk_en, 1'h1);
		go(MODE_STOP2);
		chk(illegal_op_reset, 1'h1);
		chk(in_stop, 1'h0);
		stop_allow_bit <= 1'b1;
		go(MODE_STOP2);
		chk(in_stop, 1'h1);
		chk(active_mode, MODE_STOP2);
		chk(pin_latch_hold, 1'h1);
		chk({power_ctl.ram_en, power_ctl.reg_fed_en}, 2'h2);
		chk({power_ctl.core_clk_en, power_ctl.high_freq_oscillator_en}, 2'h0);
		chk({power_ctl.low_freq_oscillator_en, power_ctl.periodic_wakeup_unit_en}, 2'h3);
		chk(power_ctl.param_regs_en, 1'h1);
		chk(power_ctl.rf_buffer_en, 1'h1);
		ack();
		chk(pin_latch_hold, 1'h1);
		wk(1);
		chk({in_stop, por_restart, wake_vector}, {2'h1, VEC_RESET});
		chk({partial_powerdown_flag, pin_latch_hold}, 2'h3);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({partial_powerdown_flag, pin_latch_hold}, 2'h3);
		ack();
		chk({partial_powerdown_flag, pin_latch_hold}, 2'h0);
		supply_above_rearm <= 1'b0;
		go(MODE_STOP1);
		chk(low_voltage_detect, 1'h1);
		chk({power_ctl.reg_fed_en, power_ctl.ram_en, power_ctl.regulator_standby}, 3'h1);
		wk(1);
		chk(in_stop, 1'h1);
		supply_above_rearm <= 1'b1;
		wk(1);
		chk({in_stop, por_restart, wake_vector}, {2'h1, VEC_RESET});
		chk(low_voltage_detect, 1'h0);
		wake_src.sensor_reading <= 1'b1;
		converter_clk_sel <= 1'b1;
		go(MODE_STOP3);
		chk(power_ctl.medium_freq_oscillator_en, 1'h1);
		chk({power_ctl.regulator_full, power_ctl.regulator_standby}, 2'h1);
		chk({power_ctl.analog_converter_en, pin_latch_hold}, 2'h0);
		wk(1);
		chk({por_restart, wake_vector}, {1'h0, VEC_IRQ});
		wake_src.sensor_reading <= 1'b0;
		go(MODE_STOP4);
		chk(power_ctl.medium_freq_oscillator_en, 1'h0);
		chk({power_ctl.regulator_full, power_ctl.regulator_standby}, 2'h2);
		chk(power_ctl.analog_converter_en, 1'h1);
		wk(2);
		chk(wake_vector, VEC_RTI);
		go(MODE_STOP3);
		wk(0);
		chk({por_restart, wake_vector}, {1'h1, VEC_RESET});
		converter_clk_sel <= 1'b0;
		rf_buffer_keep <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			lowvolt_in_stop_enable <= (i == 0);
			debug_entry_enable <= (i == 1);
			wake_src <= {i == 0, i == 1, 1'b0};
			go(i[1:0]);
			chk(power_ctl.medium_freq_oscillator_en, 1'h1);
			chk({power_ctl.analog_converter_en, power_ctl.rf_buffer_en}, 2'h0);
			chk(active_mode, MODE_STOP4);
			chk(power_ctl.regulator_full, 1'h1);
			wk(1);
			chk(wake_vector, VEC_IRQ);
		end
		end_of_test();
	end
endmodule
